// file: include/pwr_seq_if.sv
// interfaces: register strobes and dwell handshake
interface reg_access_if;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    modport bus_side (output wr, rd, addr, wdata, be, input rdata);
    modport reg_side (input wr, rd, addr, wdata, be, output rdata);
endinterface

interface dwell_if;
    logic       start;
    logic [4:0] log2;
    logic       done;
    modport seq_side   (output start, log2, input done);
    modport timer_side (input start, log2, output done);
endinterface

// file: include/pwr_seq_pkg.sv
// package: register map, fields, reset values and state codes
package pwr_seq_pkg;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] SEQ_STATUS_OFS = 8'h24;
    localparam logic [7:0] CONV_CTRL_OFS  = 8'h2c;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h50;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h54;

    // ****************************************
    // status fields and per-state config layout
    // ****************************************
    localparam int PREV_IO_BIT   = 29;
    localparam int PREV_PLL_BIT  = 28;
    localparam int PREV_ANA_BIT  = 25;
    localparam int PREV_CORE_BIT = 24;
    localparam int STATE_LSB     = 16;
    localparam int STATE_W       = 3;
    localparam int DWELL_LSB     = 16;
    localparam int DWELL_W       = 5;
    localparam int TILE_OFF_BIT  = 14;
    localparam int MOD_ANA_BIT   = 9;
    localparam int MOD_CORE_BIT  = 8;
    localparam int EN_IO_BIT     = 5;
    localparam int EN_PLL_BIT    = 4;
    localparam int EN_ANA_BIT    = 1;
    localparam int EN_CORE_BIT   = 0;

    // ****************************************
    // converter control fields
    // ****************************************
    localparam int PG_LSB       = 24;
    localparam int ERR_CLR_BIT  = 16;
    localparam int ANA_LIM_LSB  = 13;
    localparam int ANA_CLK_LSB  = 8;
    localparam int CORE_LIM_LSB = 5;
    localparam int CORE_CLK_LSB = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0] PG_RST       = 2'h2;
    localparam logic       ERR_CLR_RST  = 1'b0;
    localparam logic [1:0] ANA_LIM_RST  = 2'h0;
    localparam logic [1:0] ANA_CLK_RST  = 2'h1;
    localparam logic [1:0] CORE_LIM_RST = 2'h0;
    localparam logic [1:0] CORE_CLK_RST = 2'h1;
    localparam logic       PREV_ANA_RST = 1'b1;

    // ****************************************
    // interrupt events
    // ****************************************
    localparam int IRQ_W         = 3;
    localparam int IRQ_STATE_CHG = 0;
    localparam int IRQ_ASLEEP    = 1;
    localparam int IRQ_AWAKE     = 2;

    typedef enum logic [STATE_W-1:0] {
        SEQ_RESET,
        SEQ_ASLEEP,
        SEQ_WAKING1,
        SEQ_WAKING2,
        SEQ_AWAKE_WAIT,
        SEQ_AWAKE,
        SEQ_SLEEPING1,
        SEQ_SLEEPING2
    } seq_state_t;

endpackage

// file: src/avmm_regs_port.sv
// avalon-mm slave front end with one wait state per access
module avmm_regs_port (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // register side
    reg_access_if.bus_side   regs
);
    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
    } port_state_t;

    port_state_t cur_ff;
    port_state_t nxt_cur;

    always_comb begin
        nxt_cur     = cur_ff;
        regs.addr   = avs_address_i;
        regs.wdata  = avs_writedata_i;
        regs.be     = avs_byteenable_i;
        // commit in the cycle waitrequest is low
        regs.wr     = avs_write_i & ~cur_ff.waitreq;
        regs.rd     = avs_read_i & ~cur_ff.waitreq;
        if (!cur_ff.waitreq) begin
            nxt_cur.waitreq = 1'b1;
        end else if (avs_read_i || avs_write_i) begin
            nxt_cur.waitreq = 1'b0;
            nxt_cur.rdata   = avs_read_i ? regs.rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cur_ff <= '{waitreq: 1'b1, rdata: 32'h0000_0000};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign avs_readdata_o    = cur_ff.rdata;
    assign avs_waitrequest_o = cur_ff.waitreq;
endmodule

// file: src/dwell_timer.sv
// counts two to the power of a 5-bit value of clock cycles
module dwell_timer (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // handshake with the sequencer
    dwell_if.timer_side dw
);
    typedef struct packed {
        logic        busy;
        logic [31:0] cnt;
        logic [4:0]  lg;
    } timer_state_t;

    timer_state_t cur_ff;
    timer_state_t nxt_cur;
    logic [31:0]  limit;

    always_comb begin
        nxt_cur = cur_ff;
        limit   = (32'h0000_0001 << cur_ff.lg) - 32'h0000_0001;
        dw.done = cur_ff.busy && (cur_ff.cnt == limit);
        if (dw.start) begin
            nxt_cur.busy = 1'b1;
            nxt_cur.cnt  = 32'h0000_0000;
            nxt_cur.lg   = dw.log2;
        end else if (dw.done) begin
            nxt_cur.busy = 1'b0;
        end else if (cur_ff.busy) begin
            nxt_cur.cnt = cur_ff.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cur_ff <= '{busy: 1'b0, cnt: 32'h0000_0000, lg: 5'h00};
        end else begin
            cur_ff <= nxt_cur;
        end
    end
endmodule

// file: src/power_seq_ctrl.sv
// power sequencer with status and buck converter control registers
// Function
// RQ1 - the sequencer's present state reads back as a 3-bit code, 0 reset through 7 sleeping two.
// RQ2 - status bits 29 and 28 show the io supply and pll regulator enables of the previous state.
// RQ3 - status bits 25 and 24 show the analogue and core converter enables of the previous state.
// RQ4 - status bits 14, 9 and 8 mirror tile clock-disable and the two converter modulations.
// RQ5 - status bits 5, 4, 1 and 0 mirror the supply enables applied now, zero after reset.
// RQ6 - a 2-bit field selects the power-good threshold for both rails, reset value 2.
// RQ7 - writing one to the error-clear bit clears both converter errors and it stays until cleared.
// RQ8 - a 2-bit field selects the analogue converter current limit, reset value 0.
// RQ9 - a 2-bit field selects the analogue converter switching clock, reset value 1.
// RQ10 - a 2-bit field selects the core converter current limit, reset value 0.
// RQ11 - a 2-bit field selects the core converter switching clock, reset value 1.
// RQ12 - each timed sleeping state lasts two to the power of its programmed 5-bit value in cycles.
// RQ13 - each state applies the enables, modulations and tile clock-disable of its own config; the reset state holds them zero instead.
// RQ14 - writes to the status word and reserved bits are ignored and reserved bits read zero.
// RQ15 - previous-state flags capture the enables in force just before each transition.
module power_seq_ctrl (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    // avalon-mm slave
    input  wire logic [7:0]          avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire logic [31:0]         avs_writedata_i,
    input  wire logic [3:0]          avs_byteenable_i,
    output logic      [31:0]         avs_readdata_o,
    output logic                     avs_waitrequest_o,
    // per-state config words by state code
    input  wire logic [7:0][31:0]    state_cfg_i,
    // sequencing events
    input  wire logic                wake_req_i,
    input  wire logic                sleep_req_i,
    input  wire logic                supplies_good_i,
    input  wire logic                clock_stable_i,
    // applied supply settings
    output logic                     io_supply_output_en_o,
    output logic                     pll_supply_regulator_en_o,
    output logic                     analogue_buck_converter_en_o,
    output logic                     core_buck_converter_en_o,
    output logic                     tile_clk_off_o,
    output logic                     analogue_pfm_o,
    output logic                     core_pfm_o,
    output logic [2:0]               seq_state_o,
    // converter control
    output logic [1:0]               pg_level_o,
    output logic                     conv_err_clear_o,
    output logic [1:0]               analogue_ilim_o,
    output logic [1:0]               analogue_clk_sel_o,
    output logic [1:0]               core_ilim_o,
    output logic [1:0]               core_clk_sel_o,
    // interrupt
    output logic                     irq_o
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        pwr_seq_pkg::seq_state_t         st;
        logic                            io_en;
        logic                            pll_en;
        logic                            ana_en;
        logic                            core_en;
        logic                            tile_off;
        logic                            mod_ana;
        logic                            mod_core;
        logic                            prev_io;
        logic                            prev_pll;
        logic                            prev_ana;
        logic                            prev_core;
        logic [1:0]                      pg_lvl;
        logic                            err_clr;
        logic [1:0]                      ana_lim;
        logic [1:0]                      ana_clk;
        logic [1:0]                      core_lim;
        logic [1:0]                      core_clk;
        logic [pwr_seq_pkg::IRQ_W-1:0]   irq_sts;
        logic [pwr_seq_pkg::IRQ_W-1:0]   irq_msk;
        logic                            irq;
    } seq_ctrl_t;

    seq_ctrl_t                       cur_ff;
    seq_ctrl_t                       nxt_cur;
    logic [31:0]                     cfg_nxt;
    logic [pwr_seq_pkg::IRQ_W-1:0]   ev;
    logic                            moved;

    reg_access_if regs ();
    dwell_if      dw ();

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a[7:2] == ofs[7:2];
    endfunction

    // ****************************************
    // submodules
    // ****************************************
    avmm_regs_port u_port (
        .clk_i            (clk_i),
        .rst_b_i          (rst_b_i),
        .avs_address_i    (avs_address_i),
        .avs_read_i       (avs_read_i),
        .avs_write_i      (avs_write_i),
        .avs_writedata_i  (avs_writedata_i),
        .avs_byteenable_i (avs_byteenable_i),
        .avs_readdata_o   (avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .regs             (regs.bus_side)
    );

    dwell_timer u_dwell (
        .clk_i  (clk_i),
        .rst_b_i(rst_b_i),
        .dw     (dw.timer_side)
    );

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        regs.rdata = 32'h0000_0000; // RQ14
        if (hit(regs.addr, pwr_seq_pkg::SEQ_STATUS_OFS)) begin
            regs.rdata[pwr_seq_pkg::PREV_IO_BIT]   = cur_ff.prev_io; // RQ2
            regs.rdata[pwr_seq_pkg::PREV_PLL_BIT]  = cur_ff.prev_pll; // RQ2
            regs.rdata[pwr_seq_pkg::PREV_ANA_BIT]  = cur_ff.prev_ana; // RQ3
            regs.rdata[pwr_seq_pkg::PREV_CORE_BIT] = cur_ff.prev_core; // RQ3
            regs.rdata[pwr_seq_pkg::STATE_LSB +: pwr_seq_pkg::STATE_W] = cur_ff.st; // RQ1
            regs.rdata[pwr_seq_pkg::TILE_OFF_BIT]  = cur_ff.tile_off; // RQ4
            regs.rdata[pwr_seq_pkg::MOD_ANA_BIT]   = cur_ff.mod_ana; // RQ4
            regs.rdata[pwr_seq_pkg::MOD_CORE_BIT]  = cur_ff.mod_core; // RQ4
            regs.rdata[pwr_seq_pkg::EN_IO_BIT]     = cur_ff.io_en; // RQ5
            regs.rdata[pwr_seq_pkg::EN_PLL_BIT]    = cur_ff.pll_en; // RQ5
            regs.rdata[pwr_seq_pkg::EN_ANA_BIT]    = cur_ff.ana_en; // RQ5
            regs.rdata[pwr_seq_pkg::EN_CORE_BIT]   = cur_ff.core_en; // RQ5
        end else if (hit(regs.addr, pwr_seq_pkg::CONV_CTRL_OFS)) begin
            regs.rdata[pwr_seq_pkg::PG_LSB +: 2]       = cur_ff.pg_lvl;
            regs.rdata[pwr_seq_pkg::ERR_CLR_BIT]       = cur_ff.err_clr;
            regs.rdata[pwr_seq_pkg::ANA_LIM_LSB +: 2]  = cur_ff.ana_lim;
            regs.rdata[pwr_seq_pkg::ANA_CLK_LSB +: 2]  = cur_ff.ana_clk;
            regs.rdata[pwr_seq_pkg::CORE_LIM_LSB +: 2] = cur_ff.core_lim;
            regs.rdata[pwr_seq_pkg::CORE_CLK_LSB +: 2] = cur_ff.core_clk;
        end else if (hit(regs.addr, pwr_seq_pkg::IRQ_STATUS_OFS)) begin
            regs.rdata[pwr_seq_pkg::IRQ_W-1:0] = cur_ff.irq_sts;
        end else if (hit(regs.addr, pwr_seq_pkg::IRQ_MASK_OFS)) begin
            regs.rdata[pwr_seq_pkg::IRQ_W-1:0] = cur_ff.irq_msk;
        end
    end

    // ****************************************
    // sequencer, applied settings, registers
    // ****************************************
    always_comb begin
        nxt_cur = cur_ff;
        ev      = '0;

        // state transitions
        case (cur_ff.st)
            pwr_seq_pkg::SEQ_RESET: begin
                nxt_cur.st = pwr_seq_pkg::SEQ_WAKING1;
            end
            pwr_seq_pkg::SEQ_ASLEEP: begin
                if (wake_req_i) begin
                    nxt_cur.st = pwr_seq_pkg::SEQ_WAKING1;
                end
            end
            pwr_seq_pkg::SEQ_WAKING1: begin
                if (supplies_good_i) begin
                    nxt_cur.st = pwr_seq_pkg::SEQ_WAKING2;
                end
            end
            pwr_seq_pkg::SEQ_WAKING2: begin
                if (supplies_good_i) begin
                    nxt_cur.st = pwr_seq_pkg::SEQ_AWAKE_WAIT;
                end
            end
            pwr_seq_pkg::SEQ_AWAKE_WAIT: begin
                if (clock_stable_i) begin
                    nxt_cur.st = pwr_seq_pkg::SEQ_AWAKE;
                end
            end
            pwr_seq_pkg::SEQ_AWAKE: begin
                if (sleep_req_i) begin
                    nxt_cur.st = pwr_seq_pkg::SEQ_SLEEPING1;
                end
            end
            pwr_seq_pkg::SEQ_SLEEPING1: begin
                if (dw.done) begin
                    nxt_cur.st = pwr_seq_pkg::SEQ_SLEEPING2; // RQ12
                end
            end
            pwr_seq_pkg::SEQ_SLEEPING2: begin
                if (dw.done) begin
                    nxt_cur.st = pwr_seq_pkg::SEQ_ASLEEP; // RQ12
                end
            end
            default: begin
                nxt_cur.st = pwr_seq_pkg::SEQ_RESET;
            end
        endcase

        moved   = nxt_cur.st != cur_ff.st;
        cfg_nxt = state_cfg_i[nxt_cur.st];

        // dwell starts on entry to a timed state
        dw.start = moved && ((nxt_cur.st == pwr_seq_pkg::SEQ_SLEEPING1) ||
                             (nxt_cur.st == pwr_seq_pkg::SEQ_SLEEPING2)); // RQ12
        dw.log2  = cfg_nxt[pwr_seq_pkg::DWELL_LSB +: pwr_seq_pkg::DWELL_W]; // RQ12

        // enables of the state being left
        if (moved) begin
            nxt_cur.prev_io   = cur_ff.io_en; // RQ15
            nxt_cur.prev_pll  = cur_ff.pll_en; // RQ15
            nxt_cur.prev_ana  = cur_ff.ana_en; // RQ15
            nxt_cur.prev_core = cur_ff.core_en; // RQ15
        end

        // settings of the next state
        nxt_cur.io_en    = cfg_nxt[pwr_seq_pkg::EN_IO_BIT]; // RQ13
        nxt_cur.pll_en   = cfg_nxt[pwr_seq_pkg::EN_PLL_BIT]; // RQ13
        nxt_cur.ana_en   = cfg_nxt[pwr_seq_pkg::EN_ANA_BIT]; // RQ13
        nxt_cur.core_en  = cfg_nxt[pwr_seq_pkg::EN_CORE_BIT]; // RQ13
        nxt_cur.tile_off = cfg_nxt[pwr_seq_pkg::TILE_OFF_BIT]; // RQ13
        nxt_cur.mod_ana  = cfg_nxt[pwr_seq_pkg::MOD_ANA_BIT]; // RQ13
        nxt_cur.mod_core = cfg_nxt[pwr_seq_pkg::MOD_CORE_BIT]; // RQ13

        // control writes per lane
        if (regs.wr && hit(regs.addr, pwr_seq_pkg::CONV_CTRL_OFS)) begin
            if (regs.be[3]) begin
                nxt_cur.pg_lvl = regs.wdata[pwr_seq_pkg::PG_LSB +: 2]; // RQ6
            end
            if (regs.be[2]) begin
                nxt_cur.err_clr = regs.wdata[pwr_seq_pkg::ERR_CLR_BIT]; // RQ7
            end
            if (regs.be[1]) begin
                nxt_cur.ana_lim = regs.wdata[pwr_seq_pkg::ANA_LIM_LSB +: 2]; // RQ8
                nxt_cur.ana_clk = regs.wdata[pwr_seq_pkg::ANA_CLK_LSB +: 2]; // RQ9
            end
            if (regs.be[0]) begin
                nxt_cur.core_lim = regs.wdata[pwr_seq_pkg::CORE_LIM_LSB +: 2]; // RQ10
                nxt_cur.core_clk = regs.wdata[pwr_seq_pkg::CORE_CLK_LSB +: 2]; // RQ11
            end
        end

        // interrupt mask write
        if (regs.wr && regs.be[0] && hit(regs.addr, pwr_seq_pkg::IRQ_MASK_OFS)) begin
            nxt_cur.irq_msk = regs.wdata[pwr_seq_pkg::IRQ_W-1:0];
        end

        // events; a read clears only the bits it returned, set wins
        ev[pwr_seq_pkg::IRQ_STATE_CHG] = moved;
        ev[pwr_seq_pkg::IRQ_ASLEEP]    = moved && (nxt_cur.st == pwr_seq_pkg::SEQ_ASLEEP);
        ev[pwr_seq_pkg::IRQ_AWAKE]     = moved && (nxt_cur.st == pwr_seq_pkg::SEQ_AWAKE);
        if (regs.rd && hit(regs.addr, pwr_seq_pkg::IRQ_STATUS_OFS)) begin
            nxt_cur.irq_sts = cur_ff.irq_sts & ~avs_readdata_o[pwr_seq_pkg::IRQ_W-1:0];
        end
        nxt_cur.irq_sts = nxt_cur.irq_sts | ev;
        nxt_cur.irq     = |(nxt_cur.irq_sts & nxt_cur.irq_msk);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cur_ff           <= '0; // RQ5
            cur_ff.st        <= pwr_seq_pkg::SEQ_RESET;
            cur_ff.prev_ana  <= pwr_seq_pkg::PREV_ANA_RST; // RQ3
            cur_ff.pg_lvl    <= pwr_seq_pkg::PG_RST; // RQ6
            cur_ff.err_clr   <= pwr_seq_pkg::ERR_CLR_RST;
            cur_ff.ana_lim   <= pwr_seq_pkg::ANA_LIM_RST;
            cur_ff.ana_clk   <= pwr_seq_pkg::ANA_CLK_RST; // RQ9
            cur_ff.core_lim  <= pwr_seq_pkg::CORE_LIM_RST;
            cur_ff.core_clk  <= pwr_seq_pkg::CORE_CLK_RST; // RQ11
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign io_supply_output_en_o        = cur_ff.io_en;
    assign pll_supply_regulator_en_o    = cur_ff.pll_en;
    assign analogue_buck_converter_en_o = cur_ff.ana_en;
    assign core_buck_converter_en_o     = cur_ff.core_en;
    assign tile_clk_off_o               = cur_ff.tile_off;
    assign analogue_pfm_o               = cur_ff.mod_ana;
    assign core_pfm_o                   = cur_ff.mod_core;
    assign seq_state_o                  = cur_ff.st;
    assign pg_level_o                   = cur_ff.pg_lvl;
    assign conv_err_clear_o             = cur_ff.err_clr; // RQ7
    assign analogue_ilim_o              = cur_ff.ana_lim;
    assign analogue_clk_sel_o           = cur_ff.ana_clk;
    assign core_ilim_o                  = cur_ff.core_lim;
    assign core_clk_sel_o               = cur_ff.core_clk;
    assign irq_o                        = cur_ff.irq;

endmodule

// file: test/power_seq_ctrl_tb_top.sv
// testbench: bus, sequencer, dwell and interrupt checks
module power_seq_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clk_i = 1'b0, rst_b_i = 1'b0, rd = 1'b0, wr = 1'b0, wreq, irq;
    logic [7:0]       adr = 8'h00;
    logic [31:0]      wd = 32'h0, rdv, exp_ctl, rdata, dr;
    logic [3:0]       be = 4'h0, trig = 4'h0, b;
    logic [2:0]       s, ps, st;
    logic [7:0][31:0] cfg = '0;
    int               miscompares = 0, checked = 0, n;
    always #4 clk_i = ~clk_i;
    power_seq_ctrl i_dut (.clk_i, .rst_b_i, .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .state_cfg_i(cfg), .wake_req_i(trig[0]),
        .supplies_good_i(trig[1]), .clock_stable_i(trig[2]), .sleep_req_i(trig[3]),
        .io_supply_output_en_o(), .pll_supply_regulator_en_o(), .analogue_buck_converter_en_o(),
        .core_buck_converter_en_o(), .tile_clk_off_o(), .analogue_pfm_o(), .core_pfm_o(),
        .seq_state_o(st), .pg_level_o(), .conv_err_clear_o(), .analogue_ilim_o(),
        .analogue_clk_sel_o(), .core_ilim_o(), .core_clk_sel_o(), .irq_o(irq));
    task automatic close_out();
        if (miscompares == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] bb, output logic [31:0] q);
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        be <= bb;
        wr <= w;
        rd <= !w;
        do @(posedge clk_i); while (wreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    function automatic logic [31:0] stat(input logic [2:0] c, input logic [2:0] p);
        return (cfg[c] & 32'h0000_4333) | {2'h0, cfg[p][5:4], 2'h0, cfg[p][1:0], 5'h0, c, 16'h0};
    endfunction
    task automatic chk_st();
        bus(1'b0, 8'h24, 32'h0, 4'hf, rdv);
        chk("status", rdv, stat(s, ps));
    endtask
    task automatic step(input int i, input logic [2:0] ns);
        @(posedge clk_i);
        trig[i] <= 1'b1;
        @(posedge clk_i);
        trig <= 4'h0;
        ps = s;
        s = ns;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        close_out();
    end
    initial begin
        void'($urandom(12223));
        for (int it = 0; it < 3; it++) begin
            rst_b_i <= 1'b0;
            for (int k = 1; k < 8; k++) cfg[k] <= ($urandom & 32'h4333) | (($urandom % 4) << 16);
            repeat (2) @(posedge clk_i);
            rst_b_i <= 1'b1;
            s = 3'h2;
            ps = 3'h0;
            exp_ctl = 32'h0200_0101;
            bus(1'b0, 8'h2c, 32'h0, 4'hf, rdv);
            chk("ctrl reset", rdv, exp_ctl);
            bus(1'b0, 8'h50, 32'h0, 4'hf, rdv);
            chk("irq status", rdv, 32'h1);
            bus(1'b1, 8'h54, 32'h2, 4'hf, rdv);
            chk_st();
            step(1, 3'h3);
            chk_st();
            step(1, 3'h4);
            chk_st();
            step(2, 3'h5);
            chk_st();
            @(negedge clk_i);
            chk("irq masked", 32'(irq), 32'h0);
            step(3, 3'h6);
            @(negedge clk_i);
            for (int k = 0; k < 2; k++) begin
                n = 0;
                while (st === 3'(6 + k) && n < 40) begin
                    n++;
                    @(negedge clk_i);
                end
                chk("dwell", n, 32'd1 << cfg[6+k][20:16]);
            end
            ps = 3'h7;
            s = 3'h1;
            chk("irq raised", 32'(irq), 32'h1);
            chk_st();
            bus(1'b0, 8'h50, 32'h0, 4'hf, rdv);
            chk("irq status", rdv, 32'h7);
            @(negedge clk_i);
            chk("irq cleared", 32'(irq), 32'h0);
            repeat (4) begin
                dr = $urandom;
                b = 4'($urandom);
                bus(1'b1, 8'h2c, dr, b, rdv);
                for (int l = 0; l < 4; l++) if (b[l]) exp_ctl[8*l+:8] = dr[8*l+:8];
                exp_ctl &= 32'h0301_6363;
                bus(1'b0, 8'h2c, 32'h0, 4'hf, rdv);
                chk("ctrl", rdv, exp_ctl);
            end
            bus(1'b1, 8'h24, 32'hffff_ffff, 4'hf, rdv);
            chk_st();
            bus(1'b1, 8'h80, 32'hffff_ffff, 4'hf, rdv);
            bus(1'b0, 8'h80, 32'h0, 4'hf, rdv);
            chk("unmapped", rdv, 32'h0);
            step(0, 3'h2);
            chk_st();
        end
        close_out();
    end
endmodule

// file: test/pwr_seq_props.sv
// checker: bus, sequencer and register properties
module pwr_seq_props (
    // clock, reset and bus
    input wire logic             clk_i, rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o,
    input wire logic [7:0]       avs_address_i,
    input wire logic [31:0]      avs_writedata_i, avs_readdata_o,
    input wire logic [3:0]       avs_byteenable_i,
    // sequencer
    input wire logic [7:0][31:0] state_cfg_i,
    input wire logic             wake_req_i, io_supply_output_en_o, pll_supply_regulator_en_o,
    input wire logic             analogue_buck_converter_en_o, core_buck_converter_en_o,
    input wire logic             tile_clk_off_o, analogue_pfm_o, core_pfm_o, conv_err_clear_o,
    input wire logic [2:0]       seq_state_o,
    // converter control
    input wire logic [1:0]       pg_level_o, analogue_ilim_o, analogue_clk_sel_o, core_ilim_o,
    input wire logic [1:0]       core_clk_sel_o
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic        rd_st;
    logic        wr_ct;
    logic [6:0]  en;
    logic [31:0] cf;
    assign rd_st = avs_read_i && !avs_waitrequest_o && avs_address_i[7:2] == 6'h09;
    assign wr_ct = avs_write_i && !avs_waitrequest_o && avs_address_i[7:2] == 6'h0b;
    assign en = {tile_clk_off_o, analogue_pfm_o, core_pfm_o, io_supply_output_en_o,
                 pll_supply_regulator_en_o, analogue_buck_converter_en_o, core_buck_converter_en_o};
    assign cf = state_cfg_i[seq_state_o];
    a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("no answer");
    a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("long answer");
    a_reset_short: assert property (seq_state_o == 3'h0 |=> seq_state_o == 3'h2)
        else $error("reset not left");
    a_asleep_hold: assert property (seq_state_o == 3'h1 && !wake_req_i
        |=> seq_state_o == 3'h1) else $error("asleep left");
    a_cfg_applied: assert property (seq_state_o != 3'h0 && $stable(state_cfg_i)
        |-> en == {cf[14], cf[9:8], cf[5:4], cf[1:0]}) else $error("config not applied");
    a_status_fields: assert property (rd_st && $stable(seq_state_o)
        |-> avs_readdata_o[18:16] == seq_state_o && en == {avs_readdata_o[14],
        avs_readdata_o[9:8], avs_readdata_o[5:4], avs_readdata_o[1:0]})
        else $error("status fields");
    a_status_rsvd: assert property (rd_st |-> (avs_readdata_o & 32'hccf8_bccc) == 32'h0)
        else $error("status reserved");
    a_ctrl_rsvd: assert property (avs_read_i && !avs_waitrequest_o
        && avs_address_i[7:2] == 6'h0b |-> (avs_readdata_o & 32'hfcfe_9c9c) == 32'h0)
        else $error("control reserved");
    a_pg_write: assert property (wr_ct && avs_byteenable_i[3]
        |=> pg_level_o == $past(avs_writedata_i[25:24])) else $error("pg write");
    a_err_write: assert property (wr_ct && avs_byteenable_i[2]
        |=> conv_err_clear_o == $past(avs_writedata_i[16])) else $error("err clear write");
    a_ana_write: assert property (wr_ct && avs_byteenable_i[1] |=> analogue_clk_sel_o
        == $past(avs_writedata_i[9:8]) && analogue_ilim_o == $past(avs_writedata_i[14:13]))
        else $error("analogue write");
    a_core_write: assert property (wr_ct && avs_byteenable_i[0] |=> core_clk_sel_o
        == $past(avs_writedata_i[1:0]) && core_ilim_o == $past(avs_writedata_i[6:5]))
        else $error("core write");
    a_ctrl_hold: assert property (!wr_ct |=> $stable({pg_level_o, conv_err_clear_o,
        analogue_ilim_o, analogue_clk_sel_o, core_ilim_o, core_clk_sel_o}))
        else $error("control changed");
endmodule

bind power_seq_ctrl pwr_seq_props i_props (.*);
